// [hw/rcrs_top.sv]
// reset cause flags and reset state of the core special registers
`timescale 1ns/1ps
`default_nettype none

module rcrs_top
	import rcrs_pkg::*;
(
	input  wire logic         i_clock,
	input  wire logic         i_reset,
	input  wire rcrs_events_s i_events,
	input  wire rcrs_pmode_e  i_power_mode,
	input  wire logic         i_stack_overflow_reset_enable,
	input  wire logic         i_high_prio_int_enable,
	input  wire logic         i_low_prio_int_enable,
	input  wire logic [1:0]   i_brownout_mode_cfg,
	input  wire rcrs_pc_t     i_pc_current,
	input  wire logic         i_psel,
	input  wire logic         i_penable,
	input  wire logic         i_pwrite,
	input  wire logic [11:0]  i_paddr,
	input  wire logic [31:0]  i_pwdata,
	output var  logic [31:0]  o_prdata,
	output var  logic         o_pready,
	output var  logic         o_pslverr,
	output var  logic         o_core_reset,
	output var  logic         o_pc_load,
	output var  rcrs_pc_t     o_pc_target,
	output var  logic         o_sw_brownout_enable,
	output var  logic         o_irq
);

	////////////////////////////////////////////////////////////////////////
	// cause decode

	// picks one cause per cycle, strongest source first
	function automatic rcrs_cause_e decode_cause(input rcrs_events_s ev,
		input rcrs_pmode_e pm, input logic stk_rst_en);
		logic lowpow;
		lowpow = (pm == PMODE_IDLE) || (pm == PMODE_SLEEP);
		if (ev.poweron)
			return CAUSE_POWERON;
		else if (ev.brownout)
			return CAUSE_BROWNOUT;
		else if (ev.master_clear_pin)
			return CAUSE_MCLEAR;
		else if (ev.watchdog_timer)
			return lowpow ? CAUSE_WD_WAKE : CAUSE_WD_RESET;
		else if (ev.reset_instr)
			return CAUSE_INSTR;
		else if (ev.stack_overflow && stk_rst_en)
			return CAUSE_STK_FULL;
		else if (ev.stack_underflow)
			return stk_rst_en ? CAUSE_STK_UNF : CAUSE_STK_UNF_ER;
		else if (ev.int_wake)
			return CAUSE_INT_WAKE;
		else
			return CAUSE_NONE;
	endfunction

	// true for every cause that restarts the core at the reset address
	function automatic logic is_restart(input rcrs_cause_e c);
		return (c == CAUSE_POWERON) || (c == CAUSE_BROWNOUT) ||
			(c == CAUSE_MCLEAR) || (c == CAUSE_WD_RESET) ||
			(c == CAUSE_INSTR) || (c == CAUSE_STK_FULL) ||
			(c == CAUSE_STK_UNF);
	endfunction

	rcrs_cause_e cause;
	logic        restart;
	logic        wake;
	logic        lowpow;
	logic        gie_any;
	logic        sw_mode;
	rcrs_pc_t    pc_plus2;

	// combinational view of the current event
	assign cause    = decode_cause(i_events, i_power_mode,
		i_stack_overflow_reset_enable);
	assign restart  = is_restart(cause);
	assign wake     = (cause == CAUSE_WD_WAKE) || (cause == CAUSE_INT_WAKE);
	assign lowpow   = (i_power_mode == PMODE_IDLE) ||
		(i_power_mode == PMODE_SLEEP);
	assign gie_any  = i_high_prio_int_enable | i_low_prio_int_enable;
	assign sw_mode  = (i_brownout_mode_cfg == BROWNOUT_CFG_SW);
	assign pc_plus2 = i_pc_current + PC_STEP;

	////////////////////////////////////////////////////////////////////////
	// apb slave

	logic        wr_en;
	logic        rd_hit;
	logic [31:0] rd_data;

	// a write lands at the completing edge only
	assign wr_en = i_psel & i_penable & i_pwrite & o_pready;

	// one wait state: ready rises on the second access cycle
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= 32'h00000000;
		end
		else
		begin
			o_pready  <= i_psel & i_penable & ~o_pready;
			o_pslverr <= i_psel & i_penable & ~o_pready & ~rd_hit;
			if (i_psel & i_penable & ~o_pready & ~i_pwrite)
				o_prdata <= rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset control flags

	logic       reset_instr_flag_n;
	logic       timeout_flag_n;
	logic       powerdown_flag_n;
	logic       poweron_flag_n;
	logic       brownout_flag_n;
	logic       sw_brownout_enable;
	logic       wr_reset_control_reg;

	assign wr_reset_control_reg = wr_en && (i_paddr == OFS_RESET_CONTROL);

	// cause flags; a hardware event wins over a software write
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			{reset_instr_flag_n, timeout_flag_n, powerdown_flag_n,
				poweron_flag_n, brownout_flag_n} <= RST_FLAGS;
		else
		begin
			case (cause)
				CAUSE_POWERON:
				begin
					reset_instr_flag_n <= 1'b1;
					timeout_flag_n     <= 1'b1;
					powerdown_flag_n   <= 1'b1;
					poweron_flag_n     <= 1'b0;
					brownout_flag_n    <= 1'b0;
				end
				CAUSE_BROWNOUT:
				begin
					reset_instr_flag_n <= 1'b1;
					timeout_flag_n     <= 1'b1;
					powerdown_flag_n   <= 1'b1;
					brownout_flag_n    <= 1'b0;
				end
				CAUSE_MCLEAR:
				begin
					if (i_power_mode != PMODE_FULL)
						timeout_flag_n <= 1'b1;
					if (lowpow)
						powerdown_flag_n <= 1'b0;
				end
				CAUSE_WD_RESET:
					timeout_flag_n <= 1'b0;
				CAUSE_WD_WAKE:
				begin
					timeout_flag_n   <= 1'b0;
					powerdown_flag_n <= 1'b0;
				end
				CAUSE_INSTR:
					reset_instr_flag_n <= 1'b0;
				CAUSE_INT_WAKE:
					powerdown_flag_n <= 1'b0;
				CAUSE_NONE:
				begin
					// software may rearm the flags it owns
					if (wr_reset_control_reg)
					begin
						reset_instr_flag_n <= i_pwdata[BIT_RESET_INSTR];
						poweron_flag_n     <= i_pwdata[BIT_POWERON];
						brownout_flag_n    <= i_pwdata[BIT_BROWNOUT];
					end
				end
				default:
				begin
					// stack causes leave the cause flags alone
				end
			endcase
		end
	end

	// software brown-out enable, meaningful only in software mode
	always_ff @(posedge i_clock)
	begin
		if (i_reset || cause == CAUSE_POWERON)
			sw_brownout_enable <= sw_mode;
		else if (restart && !sw_mode)
			sw_brownout_enable <= 1'b0;
		else if (wr_reset_control_reg && sw_mode && cause == CAUSE_NONE)
			sw_brownout_enable <= i_pwdata[BIT_SW_BROWNOUT];
	end

	// the enable reaches the brown-out circuit only in software mode
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			o_sw_brownout_enable <= 1'b0;
		else
			o_sw_brownout_enable <= sw_brownout_enable & sw_mode;
	end

	////////////////////////////////////////////////////////////////////////
	// stack pointer register

	logic       stack_full_flag;
	logic       stack_underflow_flag;
	rcrs_sptr_t stack_ptr;
	logic       wr_sptr;

	assign wr_sptr = wr_en && (i_paddr == OFS_STACK_POINTER);

	// error flags: set wins, software writes zero to clear
	always_ff @(posedge i_clock)
	begin
		if (i_reset || cause == CAUSE_POWERON)
		begin
			stack_full_flag      <= 1'b0;
			stack_underflow_flag <= 1'b0;
		end
		else
		begin
			if (cause == CAUSE_STK_FULL)
				stack_full_flag <= 1'b1;
			else if (wr_sptr)
				stack_full_flag <= i_pwdata[BIT_STACK_FULL];
			if (cause == CAUSE_STK_UNF || cause == CAUSE_STK_UNF_ER)
				stack_underflow_flag <= 1'b1;
			else if (wr_sptr)
				stack_underflow_flag <= i_pwdata[BIT_STACK_UNF];
		end
	end

	// pointer: cleared by resets, bumped by a vectored wake
	always_ff @(posedge i_clock)
	begin
		if (i_reset || restart)
			stack_ptr <= '0;
		else if (cause == CAUSE_INT_WAKE && gie_any)
			stack_ptr <= stack_ptr + 5'h01;
		else if (wr_sptr)
			stack_ptr <= i_pwdata[SPTR_W-1:0];
	end

	////////////////////////////////////////////////////////////////////////
	// core special registers

	rcrs_pc_t     stack_top;
	logic [4:0]   pc_latch_upper;
	logic [7:0]   pc_latch_high;
	logic [7:0]   pc_low_byte;
	rcrs_tblptr_t table_pointer;
	logic [31:0]  scratch;

	// zeroed by resets, mostly held across a wake
	always_ff @(posedge i_clock)
	begin
		if (i_reset || restart)
		begin
			stack_top      <= '0;
			pc_latch_upper <= '0;
			pc_latch_high  <= '0;
			pc_low_byte    <= '0;
			table_pointer  <= '0;
		end
		else if (wake)
		begin
			pc_low_byte <= pc_plus2[7:0];
			if (cause == CAUSE_INT_WAKE && gie_any)
				stack_top <= i_pc_current;
		end
		else if (wr_en)
		begin
			case (i_paddr)
				OFS_STACK_TOP:
					stack_top <= i_pwdata[PC_W-1:0];
				OFS_PC_LATCH:
				begin
					pc_latch_high  <= i_pwdata[7:0];
					pc_latch_upper <= i_pwdata[LSB_PC_LATCH_UPPER +: 5];
				end
				OFS_PC_LOW_BYTE:
					pc_low_byte <= i_pwdata[7:0];
				OFS_TABLE_POINTER:
					table_pointer <= i_pwdata[TBLPTR_W-1:0];
				default:
				begin
					// other offsets do not touch these registers
				end
			endcase
		end
	end

	// unaffected register: no reset source but the chip reset touches it
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			scratch <= RST_SCRATCH;
		else if (wr_en && i_paddr == OFS_SCRATCH)
			scratch <= i_pwdata;
	end

	////////////////////////////////////////////////////////////////////////
	// restart and resume strobes to the core

	// one-cycle strobes with the address to execute next
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			o_core_reset <= 1'b0;
			o_pc_load    <= 1'b0;
			o_pc_target  <= RESTART_ADDR;
		end
		else
		begin
			o_core_reset <= restart;
			o_pc_load    <= restart | wake;
			if (restart)
				o_pc_target <= RESTART_ADDR;
			else if (cause == CAUSE_INT_WAKE && i_high_prio_int_enable)
				o_pc_target <= HIGH_VECTOR;
			else if (cause == CAUSE_INT_WAKE && i_low_prio_int_enable)
				o_pc_target <= LOW_VECTOR;
			else if (wake)
				o_pc_target <= pc_plus2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event interrupt

	rcrs_irq_t irq_status;
	rcrs_irq_t irq_mask;
	rcrs_irq_t irq_set;
	rcrs_irq_t irq_clr;

	assign irq_set = i_events;
	assign irq_clr = (wr_en && i_paddr == OFS_IRQ_STATUS) ?
		i_pwdata[IRQ_W-1:0] : '0;

	// sticky status, write one to clear, a new event wins
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			irq_status <= '0;
			irq_mask   <= RST_MASK;
			o_irq      <= 1'b0;
		end
		else
		begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
			if (wr_en && i_paddr == OFS_IRQ_MASK)
				irq_mask <= i_pwdata[IRQ_W-1:0];
			o_irq <= |(irq_status & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read mux

	always_comb
	begin
		rd_hit  = 1'b1;
		rd_data = 32'h00000000;
		case (i_paddr)
			OFS_RESET_CONTROL:
			begin
				rd_data[BIT_SW_BROWNOUT] = sw_brownout_enable & sw_mode;
				rd_data[BIT_RESET_INSTR] = reset_instr_flag_n;
				rd_data[BIT_TIMEOUT]     = timeout_flag_n;
				rd_data[BIT_POWERDOWN]   = powerdown_flag_n;
				rd_data[BIT_POWERON]     = poweron_flag_n;
				rd_data[BIT_BROWNOUT]    = brownout_flag_n;
			end
			OFS_STACK_POINTER:
			begin
				rd_data[BIT_STACK_FULL] = stack_full_flag;
				rd_data[BIT_STACK_UNF]  = stack_underflow_flag;
				rd_data[SPTR_W-1:0]     = stack_ptr;
			end
			OFS_STACK_TOP:
				rd_data[PC_W-1:0] = stack_top;
			OFS_PC_LATCH:
			begin
				rd_data[7:0] = pc_latch_high;
				rd_data[LSB_PC_LATCH_UPPER +: 5] = pc_latch_upper;
			end
			OFS_PC_LOW_BYTE:
				rd_data[7:0] = pc_low_byte;
			OFS_TABLE_POINTER:
				rd_data[TBLPTR_W-1:0] = table_pointer;
			OFS_SCRATCH:
				rd_data = scratch;
			OFS_IRQ_STATUS:
				rd_data[IRQ_W-1:0] = irq_status;
			OFS_IRQ_MASK:
				rd_data[IRQ_W-1:0] = irq_mask;
			OFS_LAST_TARGET:
				rd_data[PC_W-1:0] = o_pc_target;
			default:
				rd_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_reset);

	a_poweron_flags: assert property (
		cause == CAUSE_POWERON |=> reset_instr_flag_n && timeout_flag_n &&
		powerdown_flag_n && !poweron_flag_n && !brownout_flag_n &&
		!stack_full_flag && !stack_underflow_flag &&
		o_pc_load && o_pc_target == RESTART_ADDR)
		else $error("power-on flags or restart wrong");

	a_instr_flag: assert property (
		cause == CAUSE_INSTR && !wr_sptr |=> !reset_instr_flag_n &&
		$stable(timeout_flag_n) && $stable(powerdown_flag_n) &&
		$stable(poweron_flag_n) && $stable(stack_full_flag) && o_core_reset)
		else $error("reset instruction flags wrong");

	a_brownout_flags: assert property (
		cause == CAUSE_BROWNOUT && !wr_sptr |=> reset_instr_flag_n &&
		timeout_flag_n && powerdown_flag_n && !brownout_flag_n &&
		$stable(poweron_flag_n) && $stable(stack_underflow_flag))
		else $error("brown-out flags wrong");

	a_master_clear_pin_run: assert property (
		cause == CAUSE_MCLEAR && i_power_mode == PMODE_RUN |=>
		timeout_flag_n && $stable(powerdown_flag_n) &&
		$stable(reset_instr_flag_n) && o_pc_target == RESTART_ADDR)
		else $error("master clear in run mode wrong");

	a_master_clear_pin_sleep: assert property (
		cause == CAUSE_MCLEAR && lowpow |=> timeout_flag_n &&
		!powerdown_flag_n && $stable(brownout_flag_n))
		else $error("master clear in idle or sleep wrong");

	a_watchdog_reset: assert property (
		cause == CAUSE_WD_RESET |=> !timeout_flag_n && o_core_reset &&
		$stable(powerdown_flag_n) && o_pc_target == RESTART_ADDR)
		else $error("watchdog reset wrong");

	a_master_clear_pin_full: assert property (
		cause == CAUSE_MCLEAR && i_power_mode == PMODE_FULL |=>
		$stable(timeout_flag_n) && $stable(powerdown_flag_n) && o_core_reset)
		else $error("master clear in full power changed flags");

	a_stack_reset: assert property (
		(cause == CAUSE_STK_FULL || cause == CAUSE_STK_UNF) |=>
		(stack_full_flag || $past(cause) == CAUSE_STK_UNF) &&
		(stack_underflow_flag || $past(cause) == CAUSE_STK_FULL) &&
		o_core_reset && stack_ptr == '0 && $stable(timeout_flag_n))
		else $error("stack reset wrong");

	a_stack_error: assert property (
		cause == CAUSE_STK_UNF_ER |=> stack_underflow_flag &&
		!o_core_reset && !o_pc_load)
		else $error("underflow error must not restart");

	a_watchdog_wake: assert property (
		cause == CAUSE_WD_WAKE |=> !timeout_flag_n && !powerdown_flag_n &&
		!o_core_reset && o_pc_target == $past(pc_plus2))
		else $error("watchdog wake wrong");

	a_int_vector: assert property (
		cause == CAUSE_INT_WAKE && gie_any |=> !powerdown_flag_n &&
		o_pc_load && o_pc_target == ($past(i_high_prio_int_enable) ?
		HIGH_VECTOR : LOW_VECTOR))
		else $error("interrupt wake vector wrong");

	a_core_zero: assert property (
		restart |=> stack_top == '0 && pc_low_byte == 8'h00 &&
		table_pointer == '0 && pc_latch_high == 8'h00)
		else $error("core registers not zeroed");

	a_scratch_keep: assert property (
		cause != CAUSE_NONE && !wr_en |=> $stable(scratch))
		else $error("unaffected register changed");

	a_brownout_gate: assert property (
		!sw_mode ##1 !sw_mode |-> !o_sw_brownout_enable)
		else $error("brown-out enable active outside software mode");

endmodule

`default_nettype wire

// [hw/rcrs_pkg.sv]
// constants and types shared by the reset cause and reset state logic
package rcrs_pkg;

	// program counter and pointer widths
	localparam int unsigned PC_W     = 21;
	localparam int unsigned TBLPTR_W = 22;
	localparam int unsigned SPTR_W   = 5;
	localparam int unsigned IRQ_W    = 8;

	typedef logic [PC_W-1:0]     rcrs_pc_t;
	typedef logic [TBLPTR_W-1:0] rcrs_tblptr_t;
	typedef logic [SPTR_W-1:0]   rcrs_sptr_t;
	typedef logic [IRQ_W-1:0]    rcrs_irq_t;

	// restart and resume addresses
	localparam rcrs_pc_t RESTART_ADDR = 21'h00000;
	localparam rcrs_pc_t HIGH_VECTOR  = 21'h00008;
	localparam rcrs_pc_t LOW_VECTOR   = 21'h00018;
	localparam rcrs_pc_t PC_STEP      = 21'h00002;

	// brown-out mode configuration that hands control to software
	localparam logic [1:0] BROWNOUT_CFG_SW = 2'h1;

	// register byte offsets
	localparam logic [11:0] OFS_RESET_CONTROL = 12'h000;
	localparam logic [11:0] OFS_STACK_POINTER = 12'h004;
	localparam logic [11:0] OFS_STACK_TOP     = 12'h008;
	localparam logic [11:0] OFS_PC_LATCH      = 12'h00C;
	localparam logic [11:0] OFS_PC_LOW_BYTE   = 12'h010;
	localparam logic [11:0] OFS_TABLE_POINTER = 12'h014;
	localparam logic [11:0] OFS_SCRATCH       = 12'h018;
	localparam logic [11:0] OFS_IRQ_STATUS    = 12'h01C;
	localparam logic [11:0] OFS_IRQ_MASK      = 12'h020;
	localparam logic [11:0] OFS_LAST_TARGET   = 12'h024;

	// field positions of the reset control register
	localparam int unsigned BIT_SW_BROWNOUT = 6;
	localparam int unsigned BIT_RESET_INSTR = 4;
	localparam int unsigned BIT_TIMEOUT     = 3;
	localparam int unsigned BIT_POWERDOWN   = 2;
	localparam int unsigned BIT_POWERON     = 1;
	localparam int unsigned BIT_BROWNOUT    = 0;

	// field positions of the stack pointer register
	localparam int unsigned BIT_STACK_FULL = 7;
	localparam int unsigned BIT_STACK_UNF  = 6;

	// field positions of the pc latch register
	localparam int unsigned LSB_PC_LATCH_UPPER = 8;

	// values after reset
	localparam logic [4:0]  RST_FLAGS   = 5'h1C;
	localparam logic [31:0] RST_SCRATCH = 32'h00000000;
	localparam rcrs_irq_t   RST_MASK    = 8'h00;

	// power modes reported by the core
	typedef enum logic [1:0]
	{
		PMODE_FULL  = 2'h0,
		PMODE_RUN   = 2'h1,
		PMODE_IDLE  = 2'h2,
		PMODE_SLEEP = 2'h3
	} rcrs_pmode_e;

	// one-cycle reset and wake source pulses, bit order = irq status order
	typedef struct packed
	{
		logic int_wake;
		logic stack_underflow;
		logic stack_overflow;
		logic reset_instr;
		logic watchdog_timer;
		logic master_clear_pin;
		logic brownout;
		logic poweron;
	} rcrs_events_s;

	// decoded cause of the current cycle, one-hot
	typedef enum logic [10:0]
	{
		CAUSE_NONE       = 11'h001,
		CAUSE_POWERON    = 11'h002,
		CAUSE_BROWNOUT   = 11'h004,
		CAUSE_MCLEAR     = 11'h008,
		CAUSE_WD_RESET   = 11'h010,
		CAUSE_WD_WAKE    = 11'h020,
		CAUSE_INSTR      = 11'h040,
		CAUSE_STK_FULL   = 11'h080,
		CAUSE_STK_UNF    = 11'h100,
		CAUSE_STK_UNF_ER = 11'h200,
		CAUSE_INT_WAKE   = 11'h400
	} rcrs_cause_e;

endpackage

// [testbench/rcrs_top_tb.sv]
// self-checking bench for the reset cause and reset state logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
$display("FAIL %0t got %h exp %h", $time, a, e); end end

module rcrs_top_tb
	import rcrs_pkg::*;
;
	logic         clock   = 1'b0;
	logic         rst     = 1'b1;
	rcrs_events_s ev      = 8'h00;
	rcrs_pmode_e  pm      = PMODE_FULL;
	logic [2:0]   ctl     = 3'h4;
	logic [1:0]   cfg     = 2'h1;
	logic         psel    = 1'b0;
	logic         pen     = 1'b0;
	logic         pwr     = 1'b0;
	logic [11:0]  paddr   = 12'h000;
	logic [31:0]  pwdata  = 32'h00000000;
	logic [31:0]  prdata;
	logic [31:0]  rdv;
	logic         pready;
	logic         pslverr;
	logic         rerr;
	logic         core_rst;
	logic         pc_load;
	logic         sw_bo;
	logic         irq;
	rcrs_pc_t     tgt;
	rcrs_pc_t     pc        = 21'h00100;
	int           err_total = 0;
	int           compares  = 0;
	int           cycles    = 0;

	always #50 clock = ~clock;

	rcrs_top dut
	(
		.i_clock                       (clock),
		.i_reset                       (rst),
		.i_events                      (ev),
		.i_power_mode                  (pm),
		.i_stack_overflow_reset_enable (ctl[2]),
		.i_high_prio_int_enable        (ctl[1]),
		.i_low_prio_int_enable         (ctl[0]),
		.i_brownout_mode_cfg           (cfg),
		.i_pc_current                  (pc),
		.i_psel                        (psel),
		.i_penable                     (pen),
		.i_pwrite                      (pwr),
		.i_paddr                       (paddr),
		.i_pwdata                      (pwdata),
		.o_prdata                      (prdata),
		.o_pready                      (pready),
		.o_pslverr                     (pslverr),
		.o_core_reset                  (core_rst),
		.o_pc_load                     (pc_load),
		.o_pc_target                   (tgt),
		.o_sw_brownout_enable          (sw_bo),
		.o_irq                         (irq)
	);

	////////////////////////////////////////////////////////////////////////
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1);
		// the slave answers after exactly one wait state
		`CHK(n, 2)
		rdv = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// read a register and compare
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		`CHK(rdv, e)
	endtask

	// one event pulse, then the strobes one edge after it is sampled
	task pulse(input logic [7:0] e, input rcrs_pmode_e m,
		input logic [2:0] c, input logic r, input logic l, input rcrs_pc_t t);
		@(posedge clock);
		ev <= e;
		pm <= m;
		ctl <= c;
		@(posedge clock);
		ev <= 8'h00;
		@(posedge clock);
		`CHK(core_rst, r)
		`CHK(pc_load, l)
		if (l)
			`CHK(tgt, t)
	endtask

	////////////////////////////////////////////////////////////////////////
	// flags and pointers straight after reset
	task t_init;
		rd(OFS_RESET_CONTROL, 32'h0000005C);
		rd(OFS_STACK_POINTER, 32'h00000000);
		`CHK(sw_bo, 1'b1)
		$display("test init done");
	endtask

	// restart causes walk through the flag table
	task t_restart;
		logic [7:0]  evs [7];
		logic [1:0]  pms [7];
		logic [7:0]  exps[7];
		evs  = '{8'h04, 8'h10, 8'h08, 8'h04, 8'h08, 8'h04, 8'h02};
		pms  = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h0};
		exps = '{8'h5F, 8'h4F, 8'h47, 8'h4F, 8'h47, 8'h4B, 8'h5E};
		apb(1'b1, OFS_RESET_CONTROL, 32'h00000053);
		apb(1'b1, OFS_SCRATCH, 32'hA5A50F0F);
		apb(1'b1, OFS_STACK_TOP, 32'h00012345);
		apb(1'b1, OFS_TABLE_POINTER, 32'h00000077);
		for (int i = 0; i < 7; i++)
		begin
			pulse(evs[i], rcrs_pmode_e'(pms[i]), 3'h4, 1'b1, 1'b1, RESTART_ADDR);
			rd(OFS_RESET_CONTROL, {24'h000000, exps[i]});
		end
		rd(OFS_STACK_TOP, 32'h00000000);
		rd(OFS_TABLE_POINTER, 32'h00000000);
		rd(OFS_SCRATCH, 32'hA5A50F0F);
		$display("test restart done");
	endtask

	// watchdog and interrupt wake-ups
	task t_wake;
		apb(1'b1, OFS_STACK_TOP, 32'h00000055);
		pc <= 21'h1234E;
		pulse(8'h08, PMODE_IDLE, 3'h4, 1'b0, 1'b1, 21'h12350);
		rd(OFS_RESET_CONTROL, 32'h00000052);
		rd(OFS_PC_LOW_BYTE, 32'h00000050);
		rd(OFS_STACK_TOP, 32'h00000055);
		pulse(8'h02, PMODE_FULL, 3'h4, 1'b1, 1'b1, RESTART_ADDR);
		pulse(8'h80, PMODE_SLEEP, 3'h4, 1'b0, 1'b1, 21'h12350);
		rd(OFS_RESET_CONTROL, 32'h0000005A);
		pulse(8'h80, PMODE_SLEEP, 3'h6, 1'b0, 1'b1, HIGH_VECTOR);
		rd(OFS_STACK_TOP, 32'h0001234E);
		rd(OFS_STACK_POINTER, 32'h00000001);
		pulse(8'h80, PMODE_IDLE, 3'h5, 1'b0, 1'b1, LOW_VECTOR);
		$display("test wake done");
	endtask

	// stack errors with and without the restart enable
	task t_stack;
		pulse(8'h20, PMODE_FULL, 3'h4, 1'b1, 1'b1, RESTART_ADDR);
		rd(OFS_STACK_POINTER, 32'h00000080);
		pulse(8'h40, PMODE_FULL, 3'h0, 1'b0, 1'b0, RESTART_ADDR);
		pulse(8'h20, PMODE_FULL, 3'h0, 1'b0, 1'b0, RESTART_ADDR);
		rd(OFS_STACK_POINTER, 32'h000000C0);
		apb(1'b1, OFS_STACK_POINTER, 32'h00000000);
		pulse(8'h40, PMODE_FULL, 3'h4, 1'b1, 1'b1, RESTART_ADDR);
		rd(OFS_STACK_POINTER, 32'h00000040);
		rd(OFS_RESET_CONTROL, 32'h0000005A);
		pulse(8'h01, PMODE_FULL, 3'h4, 1'b1, 1'b1, RESTART_ADDR);
		rd(OFS_RESET_CONTROL, 32'h0000005C);
		rd(OFS_STACK_POINTER, 32'h00000000);
		rd(OFS_SCRATCH, 32'hA5A50F0F);
		$display("test stack done");
	endtask

	// software brown-out enable outside and inside mode 01
	task t_cfg;
		@(posedge clock);
		cfg <= 2'h0;
		rd(OFS_RESET_CONTROL, 32'h0000001C);
		`CHK(sw_bo, 1'b0)
		pulse(8'h04, PMODE_FULL, 3'h4, 1'b1, 1'b1, RESTART_ADDR);
		@(posedge clock);
		cfg <= 2'h1;
		rd(OFS_RESET_CONTROL, 32'h0000001C);
		pulse(8'h01, PMODE_FULL, 3'h4, 1'b1, 1'b1, RESTART_ADDR);
		rd(OFS_RESET_CONTROL, 32'h0000005C);
		`CHK(sw_bo, 1'b1)
		$display("test brown-out enable done");
	endtask

	// interrupt status, mask, clear and an unmapped offset
	task t_irq;
		rd(OFS_IRQ_STATUS, 32'h000000FF);
		`CHK(irq, 1'b0)
		apb(1'b1, OFS_IRQ_MASK, 32'h00000080);
		repeat (2) @(posedge clock);
		#1;
		`CHK(irq, 1'b1)
		apb(1'b1, OFS_IRQ_STATUS, 32'h0000007F);
		rd(OFS_IRQ_STATUS, 32'h00000080);
		apb(1'b1, OFS_IRQ_STATUS, 32'h00000080);
		repeat (2) @(posedge clock);
		#1;
		`CHK(irq, 1'b0)
		rd(OFS_LAST_TARGET, 32'h00000000);
		rd(12'h030, 32'h00000000);
		`CHK(rerr, 1'b1)
		$display("test interrupt done");
	endtask

	// chip reset in mid-run brings back the reset values
	task t_reset;
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		`CHK(core_rst, 1'b0)
		rd(OFS_RESET_CONTROL, 32'h0000005C);
		rd(OFS_IRQ_STATUS, 32'h00000000);
		$display("test reset done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task give_verdict;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// cut a hang short
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_total++;
			$display("FAIL %0t timeout", $time);
			give_verdict;
		end
	end

	// main sequence
	initial
	begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_init;
		t_restart;
		t_wake;
		t_stack;
		t_cfg;
		t_irq;
		t_reset;
		give_verdict;
	end
endmodule

`default_nettype wire
